// ==== core/iowd_defs.svh ====
`ifndef IOWD_DEFS_SVH
`define IOWD_DEFS_SVH

// I/O port addresses of the watchdog.
`define IOWD_DISARM_PORT     16'h0044
`define IOWD_ARM_PORT        16'h0444

// Timeout encoding: seconds are this base minus the written value.
`define IOWD_LEVEL_BASE      8'h80
`define IOWD_LEVEL_MAX       7'h7F

// Tick period and clock period.
`define IOWD_TICK_NS         1000000000
`define IOWD_CLK_NS          40
`define IOWD_TICK_CYCLES     (`IOWD_TICK_NS / `IOWD_CLK_NS)

// Length of the expiry pulse, in clock cycles.
`define IOWD_PULSE_CYCLES    8'h10

// Reset values.
`define IOWD_COUNT_RST       7'h00
`define IOWD_LEVEL_RST       7'h00

`endif

// ==== core/iowd_pkg.sv ====
package iowd_pkg;

  typedef enum logic [2:0] {
    IOWD_IDLE  = 3'b001,
    IOWD_RUN   = 3'b010,
    IOWD_FIRE  = 3'b100
  } iowd_state_t;

  typedef enum logic [1:0] {
    IOWD_MODE_OFF   = 2'b00,
    IOWD_MODE_NMI   = 2'b01,
    IOWD_MODE_RESET = 2'b10
  } iowd_mode_t;

endpackage

// ==== core/iowd_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defs.svh"

module iowd_prescaler
  import iowd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `IOWD_TICK_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_restart,
  output logic      o_tick
);

  logic [31:0] count;
  wire  logic  at_end = (count == TICK_CYCLES - 1);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 32'h0;
    end else if (i_restart || at_end) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= at_end && !i_restart;
    end
  end

endmodule
`default_nettype wire

// ==== core/iowd_top.sv ====
// How it works
// [R01] Inactive after reset until first arming write.
// [R02] Write 0x444 arms or restarts the countdown.
// [R03] Read 0x044 disarms; nothing fires afterwards.
// [R04] Missing refresh before interval ends fires action.
// [R05] Interrupt mode: expiry raises NMI channel check.
// [R06] Reset mode: expiry drives system reset.
// [R07] No mode selected: expiry has no effect.
// [R08] Interval programmable to 127 levels.
// [R09] Seconds equal 0x80 minus written value.
// [R10] Host writes the timeout with every arm.
// [R11] Prescaler makes one-second tick; count decrements.
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defs.svh"

module iowd_top
  import iowd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `IOWD_TICK_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_io_addr,
  input  wire logic [15:0] i_io_wdata,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [1:0]  i_watchdog_mode_select,
  output logic      [15:0] o_io_rdata,
  output logic             o_io_rd_hit,
  output logic             o_nmi_chk,
  output logic             o_sys_reset,
  output logic             o_armed
);

  iowd_state_t state;
  iowd_state_t next_state;
  logic [6:0]  level;
  logic [6:0]  remain;
  logic [7:0]  pulse;
  logic [1:0]  mode_meta;
  logic [1:0]  mode_sync;
  logic        tick;

  // Mode jumper is a board pin, brought in through two flops.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_meta <= 2'b00;
      mode_sync <= 2'b00;
    end else begin
      mode_meta <= i_watchdog_mode_select;
      mode_sync <= mode_meta;
    end
  end

  wire logic arm_hit    = i_io_wr && (i_io_addr == `IOWD_ARM_PORT); // R02
  wire logic disarm_hit = i_io_rd && (i_io_addr == `IOWD_DISARM_PORT); // R03
  // Value 0 is outside the 127 levels; it is clamped to the longest interval.
  wire logic [6:0] wr_val   = i_io_wdata[6:0]; // R10
  wire logic [6:0] wr_level = (wr_val == 7'h00) ? 7'h01 : wr_val; // R08
  // Seconds = 0x80 - value, so value 0x7F gives 1 and 0x01 gives 127.
  wire logic [7:0] secs_full = `IOWD_LEVEL_BASE - {1'b0, wr_level}; // R09
  wire logic [6:0] secs      = secs_full[6:0];
  wire logic expire = (state == IOWD_RUN) && tick && (remain == 7'h01); // R04
  wire logic in_fire = (state == IOWD_FIRE);

  iowd_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_prescaler (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_restart  (arm_hit || disarm_hit),
    .o_tick     (tick)
  ); // R11

  always_comb begin
    next_state = state;
    case (state)
      IOWD_IDLE: begin
        if (arm_hit) begin
          next_state = IOWD_RUN; // R02
        end
      end
      IOWD_RUN: begin
        if (disarm_hit) begin
          next_state = IOWD_IDLE; // R03
        end else if (arm_hit) begin
          next_state = IOWD_RUN;
        end else if (expire) begin
          next_state = IOWD_FIRE; // R04
        end
      end
      IOWD_FIRE: begin
        if (disarm_hit) begin
          next_state = IOWD_IDLE;
        end else if (arm_hit) begin
          next_state = IOWD_RUN;
        end else if (pulse == 8'h01) begin
          next_state = IOWD_IDLE;
        end
      end
      default: begin
        next_state = IOWD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= IOWD_IDLE; // R01
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level  <= `IOWD_LEVEL_RST;
      remain <= `IOWD_COUNT_RST;
    end else if (arm_hit && !disarm_hit) begin
      level  <= wr_level;
      remain <= secs; // R02
    end else if ((state == IOWD_RUN) && tick && (remain != 7'h00)) begin
      remain <= remain - 7'h01; // R11
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse <= 8'h00;
    end else if (expire) begin
      pulse <= `IOWD_PULSE_CYCLES;
    end else if (in_fire && (pulse != 8'h00)) begin
      pulse <= pulse - 8'h01;
    end
  end

  // Outputs come from flops; the mode gates which line, if any, fires.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nmi_chk   <= 1'b0;
      o_sys_reset <= 1'b0;
    end else begin
      o_nmi_chk   <= (next_state == IOWD_FIRE) && (mode_sync == IOWD_MODE_NMI); // R05
      o_sys_reset <= (next_state == IOWD_FIRE) && (mode_sync == IOWD_MODE_RESET); // R06 R07
    end
  end

  // The disarm read returns the loaded value and the seconds still left.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_rdata <= 16'h0000;
    end else if (disarm_hit) begin
      o_io_rdata <= {1'b0, remain, 1'b0, level};
    end
  end

  assign o_io_rd_hit = disarm_hit;
  assign o_armed     = (state != IOWD_IDLE);

endmodule
`default_nettype wire

// ==== tb/iowd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module iowd_host (
  input  wire logic        i_core_clk,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  // One strobe edge, then the buses park on inverted values.
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
    @(posedge i_core_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {~a, ~d, 2'h0};
  endtask
endmodule
`default_nettype wire

// ==== tb/iowd_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module iowd_top_sva #(parameter int unsigned TICK_CYCLES = 10) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [15:0] o_io_rdata,
  input wire logic        o_io_rd_hit,
  input wire logic        o_nmi_chk,
  input wire logic        o_sys_reset,
  input wire logic        o_armed
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire arm = i_io_wr && i_io_addr == 16'h0444;
  wire dis = i_io_rd && i_io_addr == 16'h0044;
  wire out = o_nmi_chk || o_sys_reset;
  a_arm_takes: assert property (arm |=> o_armed) else $error("arm");
  a_disarm_stops: assert property (dis |=> (!o_armed && !out)[*2]) else $error("disarm");
  a_hit_decode: assert property (o_io_rd_hit == dis) else $error("hit");
  a_one_action: assert property (!(o_nmi_chk && o_sys_reset)) else $error("both");
  a_idle_quiet: assert property (!o_armed |-> !out) else $error("idle");
  a_no_early: assert property (arm |=> (!out)[*8]) else $error("early");
  a_fire_armed: assert property ($rose(out) |-> $past(o_armed)) else $error("unarmed");
  a_rdata_hold: assert property (!dis |=> $stable(o_io_rdata)) else $error("rdata");
  c_nmi: cover property ($rose(o_nmi_chk));
  c_rst: cover property ($rose(o_sys_reset));
  c_dis: cover property (dis && o_armed);
endmodule
bind iowd_top iowd_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.i_core_clk, .i_rst_n,
  .i_io_addr, .i_io_wr, .i_io_rd, .o_io_rdata, .o_io_rd_hit, .o_nmi_chk, .o_sys_reset, .o_armed);
`default_nettype wire

// ==== tb/iowd_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module iowd_top_tb_top;
  localparam int TK = 10;
  logic        i_core_clk, i_rst_n;
  logic [1:0]  i_watchdog_mode_select;
  logic [15:0] i_io_addr, i_io_wdata, o_io_rdata;
  logic        i_io_wr, i_io_rd, o_io_rd_hit, o_nmi_chk, o_sys_reset, o_armed;
  int          errors, check_count, n, f;
  iowd_host u_host (.i_core_clk, .o_addr(i_io_addr), .o_wdata(i_io_wdata), .o_wr(i_io_wr), .o_rd(i_io_rd));
  iowd_top #(.TICK_CYCLES(TK)) DUT (.i_core_clk, .i_rst_n, .i_io_addr, .i_io_wdata, .i_io_wr, .i_io_rd,
    .i_watchdog_mode_select, .o_io_rdata, .o_io_rd_hit, .o_nmi_chk, .o_sys_reset, .o_armed);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wait_out(input int lim);
    for (n = 0; n < lim && !(o_nmi_chk | o_sys_reset); n++) @(negedge i_core_clk);
  endtask
  // Arms with code v and times the expiry; p is the expected {nmi, reset} pair.
  task automatic timed(input logic [6:0] v, input logic [1:0] p);
    f = (8'h80 - v) * TK;
    u_host.access(1'b1, 16'h0444, {9'h0, v});
    wait_out(f + 40);
    chk("fire", 16'(p != 0), 16'(n inside {[f - 2:f + 4]}));
    chk("pulse", 16'(p), 16'({o_nmi_chk, o_sys_reset}));
    repeat (30) @(negedge i_core_clk);
    chk("idle", 16'h0, 16'(o_armed));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (8000) @(posedge i_core_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    i_rst_n = 1'b0;
    i_watchdog_mode_select = 2'h1;
    void'($urandom(32'h838F));
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (30) @(negedge i_core_clk);
    chk("boot", 16'h0, 16'(o_armed | o_nmi_chk));
    u_host.access(1'b1, 16'h0445, 16'h007F);
    @(negedge i_core_clk);
    chk("stray", 16'h0, 16'(o_armed));
    for (int m = 0; m < 4; m++) begin
      @(posedge i_core_clk);
      i_watchdog_mode_select <= 2'(m);
      timed(7'($urandom_range(127, 120)), m == 1 ? 2'h2 : m == 2 ? 2'h1 : 2'h0);
    end
    @(posedge i_core_clk);
    i_watchdog_mode_select <= 2'h1;
    repeat (5) begin
      u_host.access(1'b1, 16'h0444, 16'h007E);
      wait_out(12);
      chk("refresh", 16'hC, 16'(n));
    end
    timed(7'h7E, 2'h2);
    u_host.access(1'b1, 16'h0444, 16'h007F);
    u_host.access(1'b0, 16'h0044, 16'h0000);
    wait_out(50);
    chk("disarm", 16'h32, 16'(n));
    chk("rdata", 16'h017F, o_io_rdata);
    timed(7'h01, 2'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
